// *** logic/vdnf_pkg.sv ***
package vdnf_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [4:0] VDNF_OFS_CTRL = 5'h00;
    localparam logic [4:0] VDNF_OFS_STAT = 5'h04;
    localparam logic [4:0] VDNF_OFS_THR = 5'h08;
    localparam logic [4:0] VDNF_OFS_REQ1 = 5'h0C;
    localparam logic [4:0] VDNF_OFS_REQ2 = 5'h10;
    localparam logic [4:0] VDNF_OFS_WIDTH = 5'h14;
    localparam logic [4:0] VDNF_OFS_VALUES = 5'h18;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int VDNF_CTRL_F1 = 0;
    localparam int VDNF_CTRL_F2 = 1;
    localparam int VDNF_CTRL_FRAME = 2;
    localparam int VDNF_CTRL_REPEAT = 3;
    localparam int VDNF_CTRL_EN = 4;
    localparam int VDNF_CTRL_CMPIE = 5;
    localparam int VDNF_STAT_F1D = 0;
    localparam int VDNF_STAT_F2D = 1;
    localparam int VDNF_STAT_WHOLE_PICTURE_DONE = 2;
    localparam int VDNF_STAT_CMP = 3;
    localparam int VDNF_STAT_NA = 4;
    localparam int VDNF_STAT_CNT = 16;
    localparam int VDNF_VAL_BLANK = 8;
    // --------------------------------------------------------------
    // values after reset and codes
    // --------------------------------------------------------------
    localparam logic [5:0] VDNF_CTRL_RST = 6'h00;
    localparam logic [7:0] VDNF_DEFAULT_RST = 8'h10;
    localparam logic [7:0] VDNF_BLANK_RST = 8'h80;
    localparam logic [7:0] VDNF_EAV_CODE = 8'hFF;
    localparam logic [2:0] VDNF_LAST_BYTE = 3'h7;
    localparam logic [31:0] VDNF_ZERO_WORD = 32'h0000_0000;
    // select codes {repeat, frame, field two, field one}
    localparam logic [3:0] VDNF_SEL_NC_F1 = 4'h1;
    localparam logic [3:0] VDNF_SEL_NC_F2 = 4'h2;
    localparam logic [3:0] VDNF_SEL_NC_BOTH = 4'h3;
    localparam logic [3:0] VDNF_SEL_NC_FRAME = 4'h4;
    localparam logic [3:0] VDNF_SEL_NC_PROG = 4'h5;
    localparam logic [3:0] VDNF_SEL_SINGLE = 4'h7;
    localparam logic [3:0] VDNF_SEL_C_F1 = 4'h9;
    localparam logic [3:0] VDNF_SEL_C_F2 = 4'hA;
    localparam logic [3:0] VDNF_SEL_C_FRAME = 4'hC;
    localparam logic [3:0] VDNF_SEL_C_PROG = 4'hD;
endpackage : vdnf_pkg

// *** logic/vdnf_line_unpack.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdnf_line_unpack #(
    parameter int CW = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raster timing
    input wire logic line_start,
    input wire logic byte_strobe,
    input wire logic in_window,
    input wire logic active_over,
    input wire logic show,
    // settings
    input wire logic [CW-1:0] image_window_width,
    input wire logic [7:0] default_value,
    input wire logic [7:0] blank_value,
    // fifo side
    input wire logic [63:0] fifo_data,
    output logic fifo_pop,
    // pixel side
    output logic [7:0] video_out,
    output logic [CW-1:0] image_pixel_counter
);
    import vdnf_pkg::*;

    logic [2:0] byte_idx;
    logic eav_sent;
    logic line_done;
    logic take;
    logic last_byte;

    // --------------------------------------------------------------
    // line position
    // --------------------------------------------------------------
    assign line_done = (image_pixel_counter == image_window_width);
    assign take = byte_strobe && in_window && !line_done;
    assign last_byte = (image_pixel_counter + CW'(1)) == image_window_width;

    // byte index restarts each line, so a line never shares a double word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_idx <= 3'h0;
            image_pixel_counter <= '0;
        end else if (line_start) begin
            byte_idx <= 3'h0;
            image_pixel_counter <= '0;
        end else if (take) begin
            image_pixel_counter <= image_pixel_counter + CW'(1);
            byte_idx <= (byte_idx == VDNF_LAST_BYTE || last_byte) ? 3'h0 : byte_idx + 3'h1;
        end
    end

    // pop on the eighth byte or at line end; the rest of the word is dropped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_pop <= 1'b0;
        end else begin
            fifo_pop <= take && show && (byte_idx == VDNF_LAST_BYTE || last_byte);
        end
    end

    // --------------------------------------------------------------
    // output byte select
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            video_out <= VDNF_DEFAULT_RST;
            eav_sent <= 1'b0;
        end else if (line_start) begin
            eav_sent <= 1'b0;
        end else if (byte_strobe) begin
            if (take) begin
                video_out <= show ? fifo_data[{byte_idx, 3'b000} +: 8] : default_value;
            end else if (line_done && active_over) begin
                video_out <= eav_sent ? blank_value : VDNF_EAV_CODE;
                eav_sent <= 1'b1;
            end else begin
                video_out <= default_value;
            end
        end
    end
endmodule : vdnf_line_unpack
`default_nettype wire

// *** logic/vdnf_display_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdnf_display_ctrl #(
    parameter int CW = 12,
    parameter int LW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // raster timing
    input wire logic field_start,
    input wire logic field_is_two,
    input wire logic field_end,
    input wire logic line_start,
    input wire logic byte_strobe,
    input wire logic in_window,
    input wire logic active_over,
    // display fifo
    input wire logic [LW-1:0] fifo_free,
    input wire logic [63:0] fifo_data,
    output logic fifo_pop,
    output logic luma_transfer_request,
    // pixel output
    output logic [7:0] video_out,
    // notification
    output logic display_complete_irq,
    output logic unacknowledged_complete_irq
);
    import vdnf_pkg::*;

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    if (CW < 1 || CW > 15) begin : g_bad_cw
        $error("count width must be 1 to 15");
    end
    if (LW < 1 || LW > 16) begin : g_bad_lw
        $error("fifo level width must be 1 to 16");
    end

    logic [5:0] display_control_reg;
    logic [LW-1:0] display_fifo_threshold;
    logic [CW-1:0] requests_per_field_one;
    logic [CW-1:0] requests_per_field_two;
    logic [CW-1:0] image_window_width;
    logic [7:0] default_value;
    logic [7:0] blank_value;
    logic [CW-1:0] display_request_countdown;
    logic [2:0] done;
    logic cmp_flag;
    logic na_flag;
    logic cur_two;
    logic armed;
    logic [3:0] sel;
    logic display_enable_bit;
    logic wr_go;
    logic rd_go;
    logic [31:0] be_mask;
    logic [31:0] wmask_data;
    logic [3:0] mode_start;
    logic [3:0] mode_cur;
    logic [2:0] set_done;
    logic [2:0] clr_done;
    logic clr_cmp;
    logic clr_na;
    logic na_event;
    logic req_go;
    logic [2:0] next_done;
    logic next_cmp;
    logic next_na;
    logic [31:0] next_readdata;

    assign sel = display_control_reg[VDNF_CTRL_REPEAT:VDNF_CTRL_F1];
    assign display_enable_bit = display_control_reg[VDNF_CTRL_EN];

    // --------------------------------------------------------------
    // mode decode: {shown, done mask frame/two/one} for one field
    // --------------------------------------------------------------
    function automatic logic [3:0] decode(input logic [3:0] s, input logic two);
        logic [3:0] r;
        r = 4'h0;
        case (s)
            VDNF_SEL_NC_F1, VDNF_SEL_C_F1: r = two ? 4'h0 : 4'h9;
            VDNF_SEL_NC_F2, VDNF_SEL_C_F2: r = two ? 4'hA : 4'h0;
            VDNF_SEL_NC_BOTH: r = two ? 4'hA : 4'h9;
            VDNF_SEL_NC_FRAME, VDNF_SEL_SINGLE, VDNF_SEL_C_FRAME: r = two ? 4'hC : 4'h8;
            VDNF_SEL_NC_PROG, VDNF_SEL_C_PROG: r = two ? 4'h0 : 4'hC;
            default: r = 4'h0;
        endcase
        return r;
    endfunction : decode

    assign mode_start = decode(sel, field_is_two);
    assign mode_cur = decode(sel, cur_two);

    // --------------------------------------------------------------
    // bus handshake: one wait cycle, then answer
    // --------------------------------------------------------------
    assign wr_go = write && !waitrequest;
    assign rd_go = read && waitrequest;

    // expand byte enables to a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_be
        assign be_mask[8*b +: 8] = {8{byteenable[b]}};
    end
    assign wmask_data = writedata & be_mask;

    // waitrequest drops for exactly the cycle after a request is seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // read data mux, unmapped offsets read as zero
    always_comb begin
        next_readdata = VDNF_ZERO_WORD;
        case (address)
            VDNF_OFS_CTRL: next_readdata = {26'h0, display_control_reg};
            VDNF_OFS_STAT: next_readdata = {1'b0, 15'(display_request_countdown), 11'h0,
                                            na_flag, cmp_flag, done};
            VDNF_OFS_THR: next_readdata = 32'(display_fifo_threshold);
            VDNF_OFS_REQ1: next_readdata = 32'(requests_per_field_one);
            VDNF_OFS_REQ2: next_readdata = 32'(requests_per_field_two);
            VDNF_OFS_WIDTH: next_readdata = 32'(image_window_width);
            VDNF_OFS_VALUES: next_readdata = {16'h0, blank_value, default_value};
            default: next_readdata = VDNF_ZERO_WORD;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= VDNF_ZERO_WORD;
        end else if (rd_go) begin
            readdata <= next_readdata;
        end
    end

    // --------------------------------------------------------------
    // software-written settings
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            display_control_reg <= VDNF_CTRL_RST;
            display_fifo_threshold <= '0;
            requests_per_field_one <= '0;
            requests_per_field_two <= '0;
            image_window_width <= '0;
            default_value <= VDNF_DEFAULT_RST;
            blank_value <= VDNF_BLANK_RST;
        end else if (wr_go) begin
            case (address)
                VDNF_OFS_CTRL: display_control_reg <= (display_control_reg & ~be_mask[5:0]) | wmask_data[5:0];
                VDNF_OFS_THR: display_fifo_threshold <=
                    (display_fifo_threshold & ~be_mask[LW-1:0]) | wmask_data[LW-1:0];
                VDNF_OFS_REQ1: requests_per_field_one <=
                    (requests_per_field_one & ~be_mask[CW-1:0]) | wmask_data[CW-1:0];
                VDNF_OFS_REQ2: requests_per_field_two <=
                    (requests_per_field_two & ~be_mask[CW-1:0]) | wmask_data[CW-1:0];
                VDNF_OFS_WIDTH: image_window_width <=
                    (image_window_width & ~be_mask[CW-1:0]) | wmask_data[CW-1:0];
                VDNF_OFS_VALUES: begin
                    if (byteenable[0]) begin
                        default_value <= writedata[7:0];
                    end
                    if (byteenable[1]) begin
                        blank_value <= writedata[VDNF_VAL_BLANK +: 8];
                    end
                end
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // done flags and notification
    // --------------------------------------------------------------
    // current field tracked from the timing strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_two <= 1'b0;
        end else if (field_start) begin
            cur_two <= field_is_two;
        end
    end

    always_comb begin
        clr_done = 3'h0;
        clr_cmp = 1'b0;
        clr_na = 1'b0;
        if (wr_go && address == VDNF_OFS_STAT && byteenable[0]) begin
            clr_done = writedata[VDNF_STAT_WHOLE_PICTURE_DONE:VDNF_STAT_F1D];
            clr_cmp = writedata[VDNF_STAT_CMP];
            clr_na = writedata[VDNF_STAT_NA];
        end
    end

    assign set_done = (field_end && display_enable_bit) ? mode_cur[2:0] : 3'h0;

    // unacknowledged only in noncontinuous modes, checked per mode style
    always_comb begin
        na_event = 1'b0;
        if (display_enable_bit && !sel[VDNF_CTRL_REPEAT]) begin
            if (field_start && !sel[VDNF_CTRL_FRAME] && |(mode_start[2:0] & done)) begin
                na_event = 1'b1;
            end
            if (field_start && sel == VDNF_SEL_SINGLE && !field_is_two && done[VDNF_STAT_WHOLE_PICTURE_DONE]) begin
                na_event = 1'b1;
            end
            if (field_end && (sel == VDNF_SEL_NC_FRAME || sel == VDNF_SEL_NC_PROG) && |(mode_cur[2:0] & done)) begin
                na_event = 1'b1;
            end
        end
    end

    // a set in the clearing cycle wins
    assign next_done = (done & ~clr_done) | set_done;
    assign next_cmp = (cmp_flag & ~clr_cmp) | (|set_done);
    assign next_na = (na_flag & ~clr_na) | na_event;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 3'h0;
            cmp_flag <= 1'b0;
            na_flag <= 1'b0;
        end else begin
            done <= next_done;
            cmp_flag <= next_cmp;
            na_flag <= next_na;
        end
    end

    // interrupt outputs track the flags in the same edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            display_complete_irq <= 1'b0;
            unacknowledged_complete_irq <= 1'b0;
        end else begin
            display_complete_irq <= next_cmp && display_control_reg[VDNF_CTRL_CMPIE];
            unacknowledged_complete_irq <= next_na;
        end
    end

    // --------------------------------------------------------------
    // fill requests
    // --------------------------------------------------------------
    // one request per threshold crossing; a request while the level still
    // sits at threshold would overfill the fifo
    assign req_go = display_enable_bit && mode_cur[3] && armed && !field_start
                    && (display_request_countdown != '0) && (fifo_free >= display_fifo_threshold);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b1;
        end else if (req_go) begin
            armed <= 1'b0;
        end else if (fifo_free < display_fifo_threshold) begin
            armed <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            display_request_countdown <= '0;
        end else if (field_start) begin
            display_request_countdown <= field_is_two ? requests_per_field_two : requests_per_field_one;
        end else if (req_go) begin
            display_request_countdown <= display_request_countdown - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            luma_transfer_request <= 1'b0;
        end else begin
            luma_transfer_request <= req_go;
        end
    end

    // --------------------------------------------------------------
    // line unpacking
    // --------------------------------------------------------------
    vdnf_line_unpack #(
        .CW(CW)
    ) u_unpack (
        .clk(clk),
        .rst(rst),
        .line_start(line_start),
        .byte_strobe(byte_strobe),
        .in_window(in_window),
        .active_over(active_over),
        .show(display_enable_bit && mode_cur[3]),
        .image_window_width(image_window_width),
        .default_value(default_value),
        .blank_value(blank_value),
        .fifo_data(fifo_data),
        .fifo_pop(fifo_pop),
        .video_out(video_out),
        .image_pixel_counter()
    );
endmodule : vdnf_display_ctrl
`default_nettype wire

// *** sim/vdnf_display_ctrl_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdnf_display_ctrl_assertions
    import vdnf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // timing and bus strobes
    input wire logic write,
    input wire logic field_start,
    input wire logic field_end,
    input wire logic byte_strobe,
    input wire logic active_over,
    // fetch and output side
    input wire logic fifo_pop,
    input wire logic luma_transfer_request,
    input wire logic [7:0] video_out,
    input wire logic display_complete_irq,
    input wire logic unacknowledged_complete_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // line end sequences, fill request, output byte and interrupt checks
    // ------------------------------------------------------------
    sequence s_eav_out;
        byte_strobe && active_over && video_out == VDNF_EAV_CODE;
    endsequence
    sequence s_new_eav;
        video_out == VDNF_EAV_CODE && $changed(video_out);
    endsequence
    chk_req_one_cycle: assert property (luma_transfer_request |=> !luma_transfer_request)
        else $error("fill request held past one cycle");
    chk_req_field_edge: assert property (field_start |=> !luma_transfer_request)
        else $error("fill request on the field start cycle");
    chk_pop_after_byte: assert property (fifo_pop |-> $past(byte_strobe))
        else $error("pop without a preceding output byte");
    chk_video_on_byte: assert property ($changed(video_out) |-> $past(byte_strobe))
        else $error("output byte changed without a strobe");
    chk_eav_once: assert property (s_eav_out |=> video_out != VDNF_EAV_CODE)
        else $error("end code repeated instead of blanking");
    chk_eav_after_active: assert property (s_new_eav |-> $past(active_over))
        else $error("end code while active video still running");
    // a done flag only appears at a field end; a control write may unmask a pending one
    chk_cmp_cause: assert property ($rose(display_complete_irq) |->
        $past(field_end) || $past(field_end, 2) || $past(write) || $past(write, 2))
        else $error("complete interrupt rose without a field end");
    chk_na_cause: assert property ($rose(unacknowledged_complete_irq) |->
        $past(field_start) || $past(field_end) || $past(field_start, 2) || $past(field_end, 2))
        else $error("unacknowledged interrupt rose between fields");
endmodule : vdnf_display_ctrl_assertions
bind vdnf_display_ctrl vdnf_display_ctrl_assertions chk_u (.clk(clk), .rst(rst), .write(write),
    .field_start(field_start), .field_end(field_end), .byte_strobe(byte_strobe), .active_over(active_over),
    .fifo_pop(fifo_pop), .luma_transfer_request(luma_transfer_request), .video_out(video_out),
    .display_complete_irq(display_complete_irq), .unacknowledged_complete_irq(unacknowledged_complete_irq));
`default_nettype wire

// *** sim/vdnf_fill_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module vdnf_fill_model #(
    parameter int DEPTH = 8,
    parameter int FILL = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the port
    input wire logic luma_transfer_request,
    input wire logic fifo_pop,
    input wire logic slow,
    // fifo view
    output logic [7:0] fifo_free,
    output logic [63:0] fifo_data
);
    int free_q, head_q, wait_q, next_free;
    // ------------------------------------------------------------
    // fill engine
    // ------------------------------------------------------------
    // a block lands some cycles after its request; slow mode stretches it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q <= 0;
        end else if (luma_transfer_request) begin
            wait_q <= slow ? 9 : 2;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end
    end
    // pops give room back, a landed block takes it; clipped so a spurious pop cannot overflow
    always_comb begin
        next_free = free_q + (fifo_pop ? 1 : 0) - (wait_q == 1 ? FILL : 0);
        next_free = (next_free > DEPTH) ? DEPTH : ((next_free < 0) ? 0 : next_free);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            free_q <= DEPTH;
            head_q <= 0;
        end else begin
            free_q <= next_free;
            head_q <= head_q + (fifo_pop ? 1 : 0);
        end
    end
    assign fifo_free = 8'(free_q);
    // byte j of word k carries k above and j below, so a wrong word or lane shows
    always_comb begin
        for (int j = 0; j < 8; j++) begin
            fifo_data[8*j +: 8] = {head_q[4:0], 3'(j)};
        end
    end
endmodule : vdnf_fill_model
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import vdnf_pkg::*;
    localparam int WID = 10;
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, slow = 1'b0;
    logic field_start = 1'b0, field_is_two = 1'b0, field_end = 1'b0, line_start = 1'b0;
    logic byte_strobe = 1'b0, in_window = 1'b0, active_over = 1'b0;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata, rd;
    logic [7:0] fifo_free, video_out;
    logic [63:0] fifo_data;
    logic waitrequest, fifo_pop, luma_transfer_request, display_complete_irq, unacknowledged_complete_irq;
    int fails = 0, cmp_count = 0, req_seen = 0, kexp = 0;
    // per select code: status after the first and the second pair of fields, fill requests per pair
    logic [7:0] st1 [16] = '{0, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h1C, 0, 8'h0C, 0, 8'h09, 8'h0A, 0, 8'h0C, 8'h0C, 0, 0};
    logic [7:0] st2 [16] = '{0, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1C, 0, 8'h1C, 0, 8'h09, 8'h0A, 0, 8'h0C, 8'h0C, 0, 0};
    logic [7:0] nreq [16] = '{0, 3, 2, 5, 5, 6, 0, 5, 0, 3, 2, 0, 5, 6, 0, 0};
    vdnf_display_ctrl dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .field_start(field_start), .field_is_two(field_is_two), .field_end(field_end), .line_start(line_start),
        .byte_strobe(byte_strobe), .in_window(in_window), .active_over(active_over), .fifo_free(fifo_free),
        .fifo_data(fifo_data), .fifo_pop(fifo_pop), .luma_transfer_request(luma_transfer_request),
        .video_out(video_out), .display_complete_irq(display_complete_irq),
        .unacknowledged_complete_irq(unacknowledged_complete_irq));
    vdnf_fill_model fill_u (.clk(clk), .rst(rst), .luma_transfer_request(luma_transfer_request),
        .fifo_pop(fifo_pop), .slow(slow), .fifo_free(fifo_free), .fifo_data(fifo_data));
    always #5 clk = ~clk;
    // count fill requests as the fetch side sees them
    always @(posedge clk) begin
        req_seen = req_seen + int'(luma_transfer_request === 1'b1);
    end
    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one bus access; held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            t++;
        end while (waitrequest !== 1'b0 && t < 40);
        if (waitrequest !== 1'b0) begin
            fails++;
            conclude();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    function automatic logic [7:0] pat(input int k, input int j);
        return {k[4:0], j[2:0]};
    endfunction : pat
    // one output byte; the registered byte is looked at one edge after it lands
    task automatic put(input logic [7:0] e, input logic c);
        @(posedge clk);
        byte_strobe <= 1'b1;
        @(posedge clk);
        byte_strobe <= 1'b0;
        @(posedge clk);
        if (c) check("video_out", {24'h00_0000, e}, {24'h00_0000, video_out});
    endtask : put
    // ------------------------------------------------------------
    // raster stimulus
    // ------------------------------------------------------------
    task automatic line(input logic sh);
        line_start <= 1'b1;
        in_window <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
        for (int n = 0; n < WID; n++) put(sh ? pat(kexp + n / 8, n % 8) : VDNF_DEFAULT_RST, 1'b1);
        kexp += sh ? (WID + 7) / 8 : 0;
        put(VDNF_DEFAULT_RST, 1'b1);
        in_window <= 1'b0;
        active_over <= 1'b1;
        put(VDNF_EAV_CODE, sh);
        put(VDNF_BLANK_RST, sh);
        active_over <= 1'b0;
    endtask : line
    task automatic field(input logic two, input logic sh);
        @(posedge clk);
        field_start <= 1'b1;
        field_is_two <= two;
        @(posedge clk);
        field_start <= 1'b0;
        repeat (8) line(sh);
        field_end <= 1'b1;
        @(posedge clk);
        field_end <= 1'b0;
        repeat (12) @(posedge clk);
    endtask : field
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic pr, sh;
        logic [7:0] e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, VDNF_OFS_VALUES, 32'h0000_0000);
        check("values", {16'h0000, VDNF_BLANK_RST, VDNF_DEFAULT_RST}, rd);
        bus(1'b0, VDNF_OFS_CTRL, 32'h0000_0000);
        check("ctrl", {26'h000_0000, VDNF_CTRL_RST}, rd);
        bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
        bus(1'b0, 5'h1C, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, rd);
        bus(1'b1, VDNF_OFS_THR, 32'h0000_0006);
        bus(1'b1, VDNF_OFS_REQ1, 32'h0000_0003);
        bus(1'b1, VDNF_OFS_REQ2, 32'h0000_0002);
        bus(1'b1, VDNF_OFS_WIDTH, 32'(WID));
        bus(1'b0, VDNF_OFS_WIDTH, 32'h0000_0000);
        check("width", 32'(WID), rd);
        // every select code, complete interrupt enabled on codes with bit 1 set, done flags left set
        for (int i = 0; i < 16; i++) begin
            slow <= i[0];
            bus(1'b1, VDNF_OFS_CTRL, {26'h000_0000, i[1], 1'b1, i[3:0]});
            bus(1'b1, VDNF_OFS_STAT, 32'h0000_001F);
            for (int p = 0; p < 2; p++) begin
                req_seen = 0;
                for (int f = 0; f < 2; f++) begin
                    pr = (i == 5 || i == 13); // progressive timing drives field one only
                    sh = nreq[i] != 8'h00 && ((f == 0 || pr) ? (i[0] || i[2]) : (i[1] || (i[2] && !i[0])));
                    field(f == 1 && !pr, sh);
                end
                check("requests", {24'h00_0000, nreq[i]}, 32'(req_seen));
                bus(1'b0, VDNF_OFS_STAT, 32'h0000_0000);
                e = p ? st2[i] : st1[i];
                check("status", {24'h00_0000, e}, rd & 32'h0000_001F);
                check("complete_irq", 32'(i[1] & e[3]), 32'(display_complete_irq));
                check("unack_irq", 32'(e[4]), 32'(unacknowledged_complete_irq));
            end
        end
        bus(1'b1, VDNF_OFS_CTRL, 32'h0000_0017);
        bus(1'b1, VDNF_OFS_STAT, 32'h0000_001F);
        field(1'b0, 1'b1);
        field(1'b1, 1'b1);
        bus(1'b1, VDNF_OFS_STAT, 32'h0000_000C);
        field(1'b0, 1'b1);
        bus(1'b0, VDNF_OFS_STAT, 32'h0000_0000);
        check("status", 32'h0000_0000, rd & 32'h0000_001F);
        conclude();
    end
    // the run needs about 25k cycles; cut a hang short well past that
    initial begin
        #900_000;
        fails++;
        conclude();
    end
endmodule : tb
`default_nettype wire
